// ### rtl/ecc_group_merge.sv
// group ecc correction and write-merge engine between bus engine and array
`include "ecc_merge_cfg.svh"
`default_nettype none
module ecc_group_merge #(
  parameter int TWR_CYCLES = `EM_TWR_NS / `EM_CLK_NS
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // bus engine side
  input  wire logic                   rdReq,
  input  wire logic [`EM_ADDR_W-1:0]  rdAddr,
  output logic                        rdValid,
  output logic [7:0]                  rdData,
  input  wire logic                   wrByte,
  input  wire logic [`EM_ADDR_W-1:0]  wrAddr,
  input  wire logic [7:0]             wrData,
  input  wire logic                   wrStop,
  output logic                        busy,
  // array side: one group word with check bits
  output logic                        arrRd,
  output logic [`EM_GROUP_W-1:0]      arrRdGrp,
  input  wire logic [31:0]            arrRdData,
  input  wire logic [`EM_CHK_W-1:0]   arrRdChk,
  output logic                        arrWr,
  output logic [`EM_GROUP_W-1:0]      arrWrGrp,
  output logic [31:0]                 arrWrData,
  output logic [`EM_CHK_W-1:0]        arrWrChk,
  output logic                        arrCommit
);
  // ------------------------------------------------------------
  // hamming(38,32) code: check bit k covers data bits whose position has bit k set
  // ------------------------------------------------------------
  function automatic logic [5:0] posOf(input int d);
    int p;
    int c;
    p = 0;
    c = 0;
    for (int q = 1; q < 40; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (c == d) p = q;
        c++;
      end
    end
    return 6'(p);
  endfunction

  function automatic logic [5:0] chkOf(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) c = c ^ posOf(i);
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [5:0]  syndrome;
  logic [31:0] flipMask;
  logic [31:0] corrected;
  assign syndrome = chkOf(arrRdData) ^ arrRdChk;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_fix
      assign flipMask[gi] = (syndrome == posOf(gi));
    end
  endgenerate
  assign corrected = arrRdData ^ flipMask;
  // a check-bit error gives a one-hot syndrome, so no data bit flips
  // two bad bits are not detected and may be miscorrected

  // ------------------------------------------------------------
  // page staging: one group per page slot, byte valid mask
  // ------------------------------------------------------------
  logic [31:0] stage_reg [`EM_PAGE_GRPS];
  logic [3:0]  bval_reg [`EM_PAGE_GRPS];
  logic [`EM_ADDR_W-8:0] pageBase_reg;
  logic [`EM_PAGE_IDX_W-1:0] slot_reg;
  logic        anyWr_reg;
  ecc_merge_pkg::state_t state_reg;
  logic [31:0] twrCnt_reg;
  logic [1:0]  rdSel_reg;

  logic [`EM_PAGE_IDX_W-1:0] wrSlot;
  logic [1:0] wrLane;
  assign wrSlot = wrAddr[6:2];
  assign wrLane = wrAddr[1:0];
  logic [`EM_GROUP_W-1:0] slotGrp;
  assign slotGrp = {pageBase_reg, slot_reg};

  // merged word: new bytes over old corrected contents
  logic [31:0] merged;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mrg
      assign merged[8*gi+:8] = bval_reg[slot_reg][gi] ? stage_reg[slot_reg][8*gi+:8]
                                                      : corrected[8*gi+:8];
    end
  endgenerate

  logic idle;
  logic inMrg;
  logic inProg;
  logic lastSlot;
  logic slotTouched;
  logic takeRd;
  logic takeByte;
  logic takeStop;
  logic twrDone;
  assign idle = (state_reg == ecc_merge_pkg::IDLE);
  assign inMrg = (state_reg == ecc_merge_pkg::MRG);
  assign inProg = (state_reg == ecc_merge_pkg::PROG);
  assign lastSlot = (slot_reg == `EM_PAGE_IDX_W'(`EM_PAGE_GRPS - 1));
  assign slotTouched = (bval_reg[slot_reg] != 4'h0);
  assign twrDone = (twrCnt_reg == 32'(TWR_CYCLES - 1));
  // read beats byte beats stop; nothing at all is taken while busy
  assign takeRd = idle && rdReq;
  assign takeByte = idle && !rdReq && wrByte;
  // a stop with nothing staged starts no write cycle
  assign takeStop = idle && !rdReq && !wrByte && wrStop && anyWr_reg;
  assign busy = !idle;
  // the scan reads a group only when the page touched it
  assign arrRd = takeRd || (inMrg && slotTouched);
  assign arrRdGrp = inMrg ? slotGrp : rdAddr[`EM_ADDR_W-1:2];

  // ------------------------------------------------------------
  // staging storage, one slot per group of the page
  // ------------------------------------------------------------
  // a later byte on a staged lane overwrites it, as the page address wraps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `EM_PAGE_GRPS; i++) begin
        bval_reg[i] <= 4'h0;
        stage_reg[i] <= 32'h0;
      end
    end else if (takeByte) begin
      stage_reg[wrSlot][8*wrLane+:8] <= wrData;
      bval_reg[wrSlot][wrLane] <= 1'b1;
    end else if (inProg) begin
      bval_reg[slot_reg] <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // control and output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ecc_merge_pkg::IDLE;
      slot_reg <= '0;
      anyWr_reg <= 1'b0;
      pageBase_reg <= '0;
      twrCnt_reg <= '0;
      rdSel_reg <= 2'h0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      arrWr <= 1'b0;
      arrWrGrp <= '0;
      arrWrData <= 32'h0;
      arrWrChk <= 6'h00;
      arrCommit <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      arrWr <= 1'b0;
      arrCommit <= 1'b0;
      case (state_reg)
        ecc_merge_pkg::IDLE: begin
          if (takeRd) begin
            rdSel_reg <= rdAddr[1:0];
            state_reg <= ecc_merge_pkg::RDWAIT;
          end else if (takeByte) begin
            // only the last page address is kept; a page write stays in one page
            pageBase_reg <= wrAddr[`EM_ADDR_W-1:7];
            anyWr_reg <= 1'b1;
          end else if (takeStop) begin
            slot_reg <= '0;
            state_reg <= ecc_merge_pkg::MRG;
          end
        end
        ecc_merge_pkg::RDWAIT: begin
          // array answers one cycle after the request
          rdData <= corrected[8*rdSel_reg+:8];
          rdValid <= 1'b1;
          state_reg <= ecc_merge_pkg::IDLE;
        end
        ecc_merge_pkg::MRG: begin
          // untouched slots take one cycle, touched ones three
          if (slotTouched) state_reg <= ecc_merge_pkg::PROG;
          else if (lastSlot) begin
            arrCommit <= 1'b1;
            twrCnt_reg <= '0;
            state_reg <= ecc_merge_pkg::BUSY;
          end else slot_reg <= slot_reg + 1'b1;
        end
        ecc_merge_pkg::PROG: begin
          arrWr <= 1'b1;
          arrWrGrp <= slotGrp;
          arrWrData <= merged;
          arrWrChk <= chkOf(merged);
          state_reg <= ecc_merge_pkg::MRG;
        end
        ecc_merge_pkg::BUSY: begin
          // no request taken until the write time elapses
          if (twrDone) begin
            anyWr_reg <= 1'b0;
            state_reg <= ecc_merge_pkg::IDLE;
          end else twrCnt_reg <= twrCnt_reg + 1'b1;
        end
        default: state_reg <= ecc_merge_pkg::IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/ecc_merge_cfg.svh
// constants for the group ecc and write-merge block
`ifndef ECC_MERGE_CFG_SVH
`define ECC_MERGE_CFG_SVH
`define EM_ADDR_W     16
`define EM_GROUP_W    14
`define EM_PAGE_BYTES 128
`define EM_PAGE_GRPS  32
`define EM_PAGE_IDX_W 5
`define EM_CHK_W      6
`define EM_TWR_NS     5000000
`define EM_CLK_NS     8
`endif

// ### rtl/ecc_merge_pkg.sv
// types for the group ecc and write-merge block
`include "ecc_merge_cfg.svh"
`default_nettype none
package ecc_merge_pkg;
  typedef enum logic [2:0] {IDLE, RDWAIT, MRG, PROG, BUSY} state_t;
endpackage
`default_nettype wire

// ### tb/ecc_array_model.sv
// array model: group words with check bits, answer one cycle after strobe
`default_nettype none
module ecc_array_model (
  input  wire logic        clk,
  input  wire logic        arrRd,
  input  wire logic [13:0] arrRdGrp,
  output var  logic [31:0] arrRdData,
  output var  logic [5:0]  arrRdChk,
  input  wire logic        arrWr,
  input  wire logic [13:0] arrWrGrp,
  input  wire logic [31:0] arrWrData,
  input  wire logic [5:0]  arrWrChk,
  input  wire logic [31:0] flipMask
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [37:0] mem [16];
  initial foreach (mem[i]) mem[i] = '0;
  // off-strobe answers invert each cycle, so a sample one cycle late never matches
  always @(posedge clk) begin
    {arrRdChk, arrRdData} <= arrRd ? mem[arrRdGrp[3:0]] ^ {6'h00, flipMask}
                                   : ~{arrRdChk, arrRdData};
    if (arrWr) mem[arrWrGrp[3:0]] <= {arrWrChk, arrWrData};
  end
endmodule
`default_nettype wire

// ### tb/ecc_group_merge_sva.sv
// assertions on the ports of the write-merge block
`default_nettype none
module ecc_group_merge_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        rdReq,
  input wire logic [15:0] rdAddr,
  input wire logic        rdValid,
  input wire logic [7:0]  rdData,
  input wire logic        wrStop,
  input wire logic        busy,
  input wire logic        arrRd,
  input wire logic [13:0] arrRdGrp,
  input wire logic        arrWr,
  input wire logic        arrCommit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_late: assert property (rdReq && !busy |-> ##2 rdValid) else $error("late");
  a_read_group: assert property (rdReq && !busy |-> arrRd && arrRdGrp == rdAddr[15:2])
    else $error("group");
  a_stray_valid: assert property (rdValid |-> $past(rdReq && !busy, 2)) else $error("stray");
  a_data_hold: assert property (!rdValid |-> $stable(rdData)) else $error("moved");
  a_busy_stop: assert property ($rose(busy) && !$past(wrStop) |-> ##1 rdValid)
    else $error("no stop");
  a_commit_hold: assert property (arrCommit |=> busy [*8]) else $error("short");
  a_merge_busy: assert property (arrWr || arrCommit |-> busy) else $error("idle wr");
  a_busy_refuse: assert property (busy && rdReq |-> ##2 !rdValid) else $error("answered");
  c_read: cover property (rdValid);
  c_commit: cover property (arrCommit);
  c_refuse: cover property (busy && rdReq);
endmodule
bind ecc_group_merge ecc_group_merge_sva chk (.*);
`default_nettype wire

// ### tb/eeprom_group_ecc_write_merge_test.sv
// bench for the group ecc and write-merge block
`default_nettype none
module eeprom_group_ecc_write_merge_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, sys_rst = 1'b1, rdReq = 1'b0, wrByte = 1'b0, wrStop = 1'b0;
  logic [15:0] rdAddr = 16'h0000, wrAddr = 16'h0000;
  logic [7:0]  wrData = 8'h00, commits = 8'h00, groupWrites = 8'h00, rdData;
  logic [31:0] flipMask = 32'h0000_0000, arrRdData, arrWrData;
  logic [13:0] arrRdGrp, arrWrGrp;
  logic [5:0]  arrRdChk, arrWrChk;
  logic        rdValid, busy, arrRd, arrWr, arrCommit;
  int          errors = 0, samples_checked = 0;
  ecc_group_merge #(.TWR_CYCLES(10)) DUT (.*);
  ecc_array_model array (.*);
  always #4 clk = ~clk;
  always @(posedge clk) if (arrCommit) commits <= commits + 8'h01;
  always @(posedge clk) if (arrWr) groupWrites <= groupWrites + 8'h01;
  task automatic give_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    int k;
    @(posedge clk);
    rdAddr <= a;
    rdReq <= 1'b1;
    @(posedge clk);
    rdReq <= 1'b0;
    // bounded wait for the one-cycle valid pulse, data taken at that edge
    for (k = 0; k < 8 && rdValid !== 1'b1; k++) @(posedge clk);
    chk(8'(k), 8'h02);
    chk(rdData, e);
  endtask
  // each group here sees at most one program cycle, far below its endurance
  task automatic wr_page(input logic [15:0] a, input int n, input logic [7:0] d);
    int   k;
    logic answered;
    answered = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wrByte <= 1'b1;
      wrAddr <= a + i[15:0];
      wrData <= d + i[7:0];
    end
    @(posedge clk);
    wrByte <= 1'b0;
    wrStop <= 1'b1;
    @(posedge clk);
    wrStop <= 1'b0;
    // a read and a stray byte while programming must both be ignored
    rdAddr <= a;
    rdReq <= 1'b1;
    wrByte <= 1'b1;
    wrAddr <= a;
    wrData <= 8'hFF;
    @(posedge clk);
    rdReq <= 1'b0;
    wrByte <= 1'b0;
    // bounded wait for the write cycle to end
    for (k = 0; k < 300 && busy !== 1'b0; k++) begin
      answered = answered | rdValid;
      @(posedge clk);
    end
    chk({7'h00, answered}, 8'h00);
    if (busy !== 1'b0) begin
      errors++;
      $display("CHECK FAILED %0t write cycle never ended", $time);
      give_verdict;
    end
  endtask
  task automatic s_byte_merge;
    wr_page(16'h0005, 1, 8'hA5);
    chk(commits, 8'h01);
    chk(groupWrites, 8'h01);
    for (int a = 4; a < 8; a++) rd(a[15:0], a == 5 ? 8'hA5 : 8'h00);
  endtask
  task automatic s_page_merge;
    wr_page(16'h000A, 8, 8'h10);
    chk(commits, 8'h02);
    chk(groupWrites, 8'h04);
    for (int a = 4; a < 20; a++)
      rd(a[15:0], a == 5 ? 8'hA5 : (a > 9 && a < 18) ? 8'h06 + a[7:0] : 8'h00);
  endtask
  task automatic s_ecc_correct;
    @(posedge clk) flipMask <= 32'h0000_0100;
    rd(16'h0005, 8'hA5);
    @(posedge clk) flipMask <= 32'h0004_0000;
    rd(16'h000E, 8'h14);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    s_byte_merge;
    s_page_merge;
    s_ecc_correct;
    give_verdict;
  end
endmodule
`default_nettype wire
